// [plp_fsm.sv]
// Operating state machine, function gating and fault reporting.
`timescale 1ns/1ps

module plp_fsm #(
  parameter logic [35:0] HEALTH_CYCLES = 36'(plp_pkg::HEALTH_CYCLES),
  parameter logic [16:0] SS_CYCLES     = 17'(plp_pkg::SS_CYCLES)
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst,
  // Asynchronous pins and comparator results
  input  plp_pkg::pins_s    pins,
  // Register access from the serial front end
  input  wire logic [7:0]   reg_addr,
  input  wire logic         reg_wr,
  input  wire logic [7:0]   reg_wdata,
  input  wire logic         reg_rd,
  output logic      [7:0]   reg_rdata,
  // Function enables
  output logic              input_switch_on,
  output logic              isolation_switch,
  output logic              boost_on,
  output logic              buck_on,
  output logic              ref_on,
  output logic              health_check_active,
  output logic      [2:0]   input_sense_high_level,
  // Indicators
  output logic              storage_good,
  output logic              output_good,
  output logic              loss_warning,
  output logic              fault_notify_n,
  output logic              fault_notify_oe_n
);

  // -----------------------------------------------------------------------
  // Input synchronisation
  // -----------------------------------------------------------------------
  plp_pkg::pins_s sync;

  pin_sync #(.WIDTH($bits(plp_pkg::pins_s))) u_sync (
    .clk     (clk),
    .rst     (rst),
    .raw     (pins),
    .settled (sync)
  );

  // -----------------------------------------------------------------------
  // Fault classification
  // -----------------------------------------------------------------------
  logic       high_fault, supp_fault, ready_ok;
  logic [7:0] raw_status;
  plp_pkg::state_e state_q, state_d;
  plp_pkg::control_s ctrl_q, ctrl_d;

  assign high_fault = sync.sense_above_high &&
                      (ctrl_q.high_level != plp_pkg::HIGH_LEVEL_OFF);
  assign supp_fault = !sync.sense_above_low || high_fault || sync.input_ov ||
                      sync.switch_oc || sync.drop_over_300mv || !sync.enable;
  assign ready_ok = sync.out_iso_under_200mv && !sync.temp_over_145 &&
                    sync.ref_valid && sync.boot_ok && sync.comp_ok;

  always_comb begin
    raw_status = '0;
    raw_status[plp_pkg::FLT_SENSE_LOW]  = !sync.sense_above_low;
    raw_status[plp_pkg::FLT_SENSE_HIGH] = high_fault;
    raw_status[plp_pkg::FLT_INPUT_OV]   = sync.input_ov;
    raw_status[plp_pkg::FLT_SWITCH_OC]  = sync.switch_oc;
    raw_status[plp_pkg::FLT_DROP]       = sync.drop_over_300mv;
    raw_status[plp_pkg::FLT_HOT]        = sync.temp_over_145;
    raw_status[plp_pkg::FLT_NOT_READY]  = !ready_ok;
    raw_status[plp_pkg::FLT_SUPPLEMENT] = (state_q == plp_pkg::supplement);
  end

  // -----------------------------------------------------------------------
  // Register file
  // -----------------------------------------------------------------------
  logic [7:0] mask_q, mask_d, latch_q, latch_d, prev_q, rdata_d, event_v;
  logic       wr_ctl, hc_done;

  assign wr_ctl  = reg_wr && (reg_addr == plp_pkg::ADDR_CONTROL);
  assign hc_done = (state_q == plp_pkg::health_check) &&
                   (state_d == plp_pkg::normal);
  assign event_v = (raw_status ^ prev_q) & ~mask_q;

  always_comb begin
    ctrl_d = ctrl_q;
    mask_d = mask_q;
    // Self-clearing bits fall first so a write in the same cycle wins.
    if (state_q == plp_pkg::undervoltage_hold_state) begin
      ctrl_d.power_off = 1'b0;
    end
    if (hc_done) begin
      ctrl_d.health_trigger = 1'b0;
    end
    if (wr_ctl) begin
      ctrl_d.power_off      = reg_wdata[plp_pkg::CTL_POWER_OFF_BIT];
      ctrl_d.health_trigger = reg_wdata[plp_pkg::CTL_HEALTH_BIT] ||
                              ctrl_d.health_trigger;
      ctrl_d.iso_enable     = reg_wdata[plp_pkg::CTL_ISO_EN_BIT];
      ctrl_d.high_level     =
        reg_wdata[plp_pkg::CTL_HIGH_MSB:plp_pkg::CTL_HIGH_LSB];
    end else if (reg_wr && (reg_addr == plp_pkg::ADDR_MASK)) begin
      mask_d = reg_wdata;
    end
    // Reading keeps bits whose fault is still present and unmasked; new events win.
    latch_d = latch_q | event_v;
    if (reg_rd && (reg_addr == plp_pkg::ADDR_FAULT)) begin
      latch_d = (latch_q & raw_status & ~mask_q) | event_v;
    end
    if (reg_addr == plp_pkg::ADDR_STATE) begin
      rdata_d = {5'h00, state_q};
    end else if (reg_addr == plp_pkg::ADDR_FAULT) begin
      rdata_d = latch_q;
    end else if (reg_addr == plp_pkg::ADDR_MASK) begin
      rdata_d = mask_q;
    end else if (reg_addr == plp_pkg::ADDR_CONTROL) begin
      rdata_d = {1'b0, ctrl_q.high_level, 1'b0, ctrl_q.iso_enable,
                 ctrl_q.health_trigger, ctrl_q.power_off};
    end else begin
      rdata_d = 8'h00;
    end
    if (!reg_rd) begin
      rdata_d = reg_rdata;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl_q    <= '{high_level: plp_pkg::DEFAULT_CODE_IDX, default: 1'b0};
      mask_q    <= plp_pkg::MASK_RESET;
      latch_q   <= 8'h00;
      prev_q    <= 8'h00;
      reg_rdata <= 8'h00;
    end else begin
      ctrl_q    <= ctrl_d;
      mask_q    <= mask_d;
      latch_q   <= latch_d;
      prev_q    <= raw_status;
      reg_rdata <= rdata_d;
    end
  end

  // -----------------------------------------------------------------------
  // Timers and state machine
  // -----------------------------------------------------------------------
  logic [35:0] hc_cnt_q, hc_cnt_d;
  logic [16:0] ss_cnt_q, ss_cnt_d;
  logic        pass_q, pass_d;

  always_comb begin
    state_d  = state_q;
    pass_d   = pass_q;
    hc_cnt_d = hc_cnt_q;
    ss_cnt_d = 17'h00000;
    case (state_q)
      plp_pkg::undervoltage_hold_state: begin
        if (sync.power_present && sync.enable && sync.sense_above_low &&
            !ctrl_q.power_off) begin
          state_d = plp_pkg::soft_start;
        end
      end
      plp_pkg::soft_start: begin
        if (sync.in_out_under_200mv) begin
          ss_cnt_d = ss_cnt_q + 17'h00001;
        end
        if (supp_fault) begin
          state_d = plp_pkg::undervoltage_hold_state;
        end else if (sync.in_out_under_200mv && ss_cnt_q >= SS_CYCLES) begin
          state_d = plp_pkg::normal;
          pass_d  = 1'b1;
        end
      end
      plp_pkg::normal, plp_pkg::health_check: begin
        hc_cnt_d = hc_cnt_q + 36'h000000001;
        if (supp_fault) begin
          state_d = plp_pkg::supplement;
        end else if (!ready_ok || pass_q) begin
          state_d = plp_pkg::supplement_disable;
          pass_d  = 1'b0;
        end else if (state_q == plp_pkg::health_check) begin
          hc_cnt_d = 36'h000000000;
          if (sync.health_done) begin
            state_d = plp_pkg::normal;
          end
        end else if (hc_cnt_q >= HEALTH_CYCLES - 36'h000000001 ||
                     ctrl_q.health_trigger) begin
          state_d  = plp_pkg::health_check;
          hc_cnt_d = 36'h000000000;
        end
      end
      plp_pkg::supplement: begin
        if (sync.storage_depleted) begin
          state_d = plp_pkg::undervoltage_hold_state;
        end
      end
      plp_pkg::supplement_disable: begin
        // Input faults cannot reach supplement here; only enable loss, power loss
        // or the power-off bit drop the device back to the hold state.
        if (!sync.enable || !sync.power_present) begin
          state_d = plp_pkg::undervoltage_hold_state;
        end else if (sync.storage_charged && ready_ok &&
                     sync.storage_path_enable) begin
          state_d = plp_pkg::normal;
        end
      end
      plp_pkg::shutdown: begin
        if (!sync.temp_over_155 && !sync.switch_oc) begin
          state_d = plp_pkg::soft_start;
        end
      end
      default: state_d = plp_pkg::undervoltage_hold_state;
    endcase
    if (ctrl_q.power_off && state_q != plp_pkg::shutdown) begin
      state_d = plp_pkg::undervoltage_hold_state;
    end
    if (sync.temp_over_155) begin
      state_d = plp_pkg::shutdown;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_q  <= plp_pkg::undervoltage_hold_state;
      pass_q   <= 1'b0;
      hc_cnt_q <= 36'h000000000;
      ss_cnt_q <= 17'h00000;
    end else begin
      state_q  <= state_d;
      pass_q   <= pass_d;
      hc_cnt_q <= hc_cnt_d;
      ss_cnt_q <= ss_cnt_d;
    end
  end

  // -----------------------------------------------------------------------
  // Function gating and indicators
  // -----------------------------------------------------------------------
  logic sw_d, iso_d, boost_d, buck_d, ref_d, hca_d, sg_d, og_d, lw_d;
  logic run_d;

  always_comb begin
    run_d   = (state_d == plp_pkg::normal) ||
              (state_d == plp_pkg::health_check);
    sw_d    = (run_d || state_d == plp_pkg::soft_start ||
               state_d == plp_pkg::supplement_disable) &&
              sync.enable && sync.sense_above_low;
    boost_d = run_d && sync.storage_path_enable;
    buck_d  = (state_d == plp_pkg::supplement) &&
              sync.storage_path_enable;
    if (state_d == plp_pkg::supplement_disable) begin
      iso_d = sync.storage_path_enable || ctrl_q.iso_enable;
    end else begin
      iso_d = (run_d || state_d == plp_pkg::supplement) &&
              sync.storage_path_enable;
    end
    ref_d   = (state_d != plp_pkg::undervoltage_hold_state) &&
              (state_d != plp_pkg::shutdown);
    hca_d   = (state_d == plp_pkg::health_check);
    sg_d    = run_d && !pass_d;
    og_d    = (state_d != plp_pkg::undervoltage_hold_state) &&
              (state_d != plp_pkg::shutdown) &&
              (state_d != plp_pkg::soft_start);
    lw_d    = og_d && (state_d != plp_pkg::supplement);
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      input_switch_on        <= 1'b0;
      isolation_switch       <= 1'b0;
      boost_on               <= 1'b0;
      buck_on                <= 1'b0;
      ref_on                 <= 1'b0;
      health_check_active    <= 1'b0;
      input_sense_high_level <= plp_pkg::DEFAULT_CODE_IDX;
      storage_good           <= 1'b0;
      output_good            <= 1'b0;
      loss_warning           <= 1'b0;
      fault_notify_n         <= 1'b0;
      fault_notify_oe_n      <= 1'b1;
    end else begin
      input_switch_on        <= sw_d;
      isolation_switch       <= iso_d;
      boost_on               <= boost_d;
      buck_on                <= buck_d;
      ref_on                 <= ref_d;
      health_check_active    <= hca_d;
      input_sense_high_level <= ctrl_d.high_level;
      storage_good           <= sg_d;
      output_good            <= og_d;
      loss_warning           <= lw_d;
      fault_notify_n         <= 1'b0;
      fault_notify_oe_n      <= (latch_d == 8'h00);
    end
  end

  // -----------------------------------------------------------------------
  // Assertions
  // -----------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_hot_shutdown: assert property (
    sync.temp_over_155 |=> state_q == plp_pkg::shutdown ##0
      !input_switch_on && !ref_on)
    else $error("over temperature did not shut down");
  a_supp_buck_on: assert property (
    state_d == plp_pkg::supplement && sync.storage_path_enable
      |=> buck_on && !input_switch_on && !loss_warning)
    else $error("supplement entry did not switch paths");
  a_sdis_blocks: assert property (
    state_q == plp_pkg::supplement_disable
      |-> !storage_good ##1 state_q != plp_pkg::supplement)
    else $error("supplement-disable let supplement in");
  a_path_low_off: assert property (
    !sync.storage_path_enable |=> !boost_on && !buck_on)
    else $error("storage path low left converters on");
  a_health_clear: assert property (
    hc_done && !wr_ctl |=> !ctrl_q.health_trigger)
    else $error("health trigger not cleared");
  a_irq_event: assert property (
    event_v != 8'h00 |=> !fault_notify_oe_n && fault_notify_n == 1'b0)
    else $error("unmasked change did not notify");
  a_pass_through: assert property (
    state_q == plp_pkg::soft_start && state_d == plp_pkg::normal &&
    !sync.temp_over_155 |=> state_q == plp_pkg::normal ##1
      state_q != plp_pkg::health_check)
    else $error("soft-start exit did not pass through normal");
  a_ss_wait: assert property (
    state_q == plp_pkg::soft_start && ss_cnt_q < SS_CYCLES
      |=> state_q != plp_pkg::normal)
    else $error("soft-start left before its timer");
  a_power_off: assert property (
    ctrl_q.power_off && !sync.temp_over_155 &&
    state_q != plp_pkg::shutdown
      |=> state_q == plp_pkg::undervoltage_hold_state)
    else $error("power-off trigger ignored");

  c_supplement: cover property (state_q == plp_pkg::supplement);
  c_health: cover property (
    state_q == plp_pkg::health_check ##1 state_q == plp_pkg::normal);
  c_charged: cover property (
    state_q == plp_pkg::supplement_disable ##1 state_q == plp_pkg::normal);

endmodule : plp_fsm

// [plp_pkg.sv]
// Shared constants, register map, state and pin types of the protection FSM.
package plp_pkg;

  // ---------------------------------------------------------------------
  // Clock and timing
  // ---------------------------------------------------------------------
  localparam longint unsigned CLK_HZ           = 125_000_000;
  localparam longint unsigned HEALTH_PERIOD_MIN = 4;
  localparam longint unsigned HEALTH_CYCLES    =
    HEALTH_PERIOD_MIN * 64'd60 * CLK_HZ;
  localparam longint unsigned SS_SETTLE_US     = 1000;
  localparam longint unsigned SS_CYCLES        =
    (SS_SETTLE_US * CLK_HZ + 64'd999_999) / 64'd1_000_000;

  // ---------------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------------
  localparam logic [7:0] ADDR_STATE   = 8'h00;
  localparam logic [7:0] ADDR_FAULT   = 8'h01;
  localparam logic [7:0] ADDR_MASK    = 8'h02;
  localparam logic [7:0] ADDR_CONTROL = 8'h06;

  localparam int CTL_POWER_OFF_BIT = 0;
  localparam int CTL_HEALTH_BIT    = 1;
  localparam int CTL_ISO_EN_BIT    = 2;
  localparam int CTL_HIGH_LSB      = 4;
  localparam int CTL_HIGH_MSB      = 6;

  localparam logic [2:0] HIGH_LEVEL_OFF   = 3'h0;
  localparam logic [2:0] DEFAULT_CODE_IDX = 3'h7;
  localparam logic [7:0] MASK_RESET       = 8'h00;

  // Fault status bit positions.
  localparam int FLT_SENSE_LOW  = 0;
  localparam int FLT_SENSE_HIGH = 1;
  localparam int FLT_INPUT_OV   = 2;
  localparam int FLT_SWITCH_OC  = 3;
  localparam int FLT_DROP       = 4;
  localparam int FLT_HOT        = 5;
  localparam int FLT_NOT_READY  = 6;
  localparam int FLT_SUPPLEMENT = 7;

  // ---------------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------------
  typedef enum logic [2:0] {
    undervoltage_hold_state,
    soft_start,
    normal,
    health_check,
    supplement,
    supplement_disable,
    shutdown
  } state_e;

  typedef struct packed {
    logic power_present;
    logic enable;
    logic storage_path_enable;
    logic sense_above_low;
    logic sense_above_high;
    logic input_ov;
    logic switch_oc;
    logic drop_over_300mv;
    logic in_out_under_200mv;
    logic out_iso_under_200mv;
    logic temp_over_145;
    logic temp_over_155;
    logic ref_valid;
    logic boot_ok;
    logic comp_ok;
    logic storage_charged;
    logic storage_depleted;
    logic health_done;
  } pins_s;

  typedef struct packed {
    logic [2:0] high_level;
    logic       iso_enable;
    logic       health_trigger;
    logic       power_off;
  } control_s;

endpackage : plp_pkg

// [pin_sync.sv]
// Three-stage synchroniser for a group of asynchronous inputs.
`timescale 1ns/1ps
module pin_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst,
  // Raw and settled levels
  input  wire logic [WIDTH-1:0] raw,
  output logic      [WIDTH-1:0] settled
);

  logic [WIDTH-1:0] s1_q, s2_q, s3_q, out_q;
  logic [WIDTH-1:0] out_d;

  // A bit only moves once the second and third stages agree, which
  // rejects a single-cycle glitch escaping the first stage.
  always_comb begin
    for (int i = 0; i < WIDTH; i++) begin
      out_d[i] = (s2_q[i] == s3_q[i]) ? s3_q[i] : out_q[i];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s1_q  <= '0;
      s2_q  <= '0;
      s3_q  <= '0;
      out_q <= '0;
    end else begin
      s1_q  <= raw;
      s2_q  <= s1_q;
      s3_q  <= s2_q;
      out_q <= out_d;
    end
  end

  assign settled = out_q;

endmodule : pin_sync

// [plp_plant.sv]
// Behavioural model of the storage bank and health routine at the far side.
`timescale 1ns/1ps
module plp_plant (
  // Clock
  input  wire logic clk,
  // Device controls
  input  wire logic iso_on,
  input  wire logic buck_on,
  input  wire logic health_on,
  // Storage and health results
  output logic      charged,
  output logic      depleted,
  output logic      health_done
);
  // -----------------------------------------------------------------------
  // Slow analog behaviour
  // -----------------------------------------------------------------------
  // Counts stand in for capacitor charge and drain, so both take real time.
  int unsigned iso_cnt = 0;
  int unsigned buck_cnt = 0;
  int unsigned chk_cnt = 0;
  always @(posedge clk) begin
    iso_cnt  <= iso_on ? iso_cnt + 1 : 0;
    buck_cnt <= buck_on ? buck_cnt + 1 : 0;
    chk_cnt  <= health_on ? chk_cnt + 1 : 0;
  end
  assign charged     = iso_on && (iso_cnt >= 30);
  assign depleted    = buck_on && (buck_cnt >= 40);
  assign health_done = health_on && (chk_cnt >= 10);
endmodule : plp_plant

// [power_loss_protection_fsm_test.sv]
// Self-checking testbench of the protection state machine.
`timescale 1ns/1ps
module power_loss_protection_fsm_test;
  // -----------------------------------------------------------------------
  // Signals
  // -----------------------------------------------------------------------
  logic           clk = 1'b0;
  logic           rst = 1'b1;
  plp_pkg::pins_s drv = '0;
  plp_pkg::pins_s pins;
  logic [7:0]     reg_addr = 8'h00;
  logic           reg_wr = 1'b0;
  logic [7:0]     reg_wdata = 8'h00;
  logic           reg_rd = 1'b0;
  logic [7:0]     reg_rdata;
  logic           sw, iso, bst, bck, rf, hc, sg, og, lw, irq, irq_oe_n;
  logic [2:0]     high_lvl;
  logic           charged, depleted, hdone;
  int             fail_count = 0;
  int             num_checks = 0;
  int             cycles = 0;
  logic [7:0]     d;

  always #4 clk = ~clk;
  always_comb begin
    pins = drv;
    pins.storage_charged  = charged;
    pins.storage_depleted = depleted;
    pins.health_done      = hdone;
  end

  plp_fsm #(.HEALTH_CYCLES(36'h000000190), .SS_CYCLES(17'h00014)) dut (
    .clk(clk), .rst(rst), .pins(pins), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .input_switch_on(sw), .isolation_switch(iso),
    .boost_on(bst), .buck_on(bck), .ref_on(rf), .health_check_active(hc),
    .input_sense_high_level(high_lvl), .storage_good(sg),
    .output_good(og), .loss_warning(lw), .fault_notify_n(irq),
    .fault_notify_oe_n(irq_oe_n));

  plp_plant plant (.clk(clk), .iso_on(iso), .buck_on(bck), .health_on(hc),
    .charged(charged), .depleted(depleted), .health_done(hdone));

  // -----------------------------------------------------------------------
  // Tasks
  // -----------------------------------------------------------------------
  task automatic end_of_test();
    $display("checks=%0d mismatches=%0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : end_of_test

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk) #1;
    reg_addr  = a;
    reg_wdata = v;
    reg_wr    = 1'b1;
    @(posedge clk) #1;
    reg_wr = 1'b0;
  endtask : wr

  // Data is taken 1 ns after the edge that accepted the read, which registers it.
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge clk) #1;
    reg_addr = a;
    reg_rd   = 1'b1;
    @(posedge clk) #1;
    reg_rd = 1'b0;
    v      = reg_rdata;
  endtask : rd

  // Two equal reads in a row are needed, so the one-cycle pass through
  // normal after soft-start is not taken for a settled state.
  task automatic wait_state(input logic [7:0] s);
    int i;
    logic [7:0] p;
    p = 8'hff;
    for (i = 0; i < 300; i++) begin
      rd(plp_pkg::ADDR_STATE, d);
      if (d === s && p === s) break;
      p = d;
    end
    chk(d, s);
  endtask : wait_state

  task automatic idle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : idle

  // Bit order: input switch, isolation, boost, buck, reference.
  function automatic logic [7:0] en();
    return {3'h0, sw, iso, bst, bck, rf};
  endfunction : en

  always @(posedge clk) begin
    cycles++;
    if (cycles == 40000) begin
      fail_count++;
      end_of_test();
    end
  end

  // -----------------------------------------------------------------------
  // Tests
  // -----------------------------------------------------------------------
  initial begin
    repeat (20) @(posedge clk);
    #1;
    rst = 1'b0;
    rd(plp_pkg::ADDR_STATE, d);
    chk(d, 8'h00);
    rd(plp_pkg::ADDR_CONTROL, d);
    chk(d, 8'h70);
    rd(plp_pkg::ADDR_MASK, d);
    chk(d, plp_pkg::MASK_RESET);
    rd(8'h33, d);
    chk(d, 8'h00);
    chk({5'h0, high_lvl}, 8'h07);
    drv.power_present = 1'b1;
    drv.sense_above_low = 1'b1;
    drv.in_out_under_200mv = 1'b1;
    drv.out_iso_under_200mv = 1'b1;
    drv.ref_valid = 1'b1;
    drv.boot_ok = 1'b1;
    drv.comp_ok = 1'b1;
    drv.storage_path_enable = 1'b1;
    idle(40);
    rd(plp_pkg::ADDR_STATE, d);
    chk(d, 8'h00);
    chk(en(), 8'h00);
    drv.enable = 1'b1;
    wait_state(8'h05);
    chk({7'h0, sg}, 8'h00);
    chk(en(), 8'h19);
    wait_state(8'h02);
    chk({5'h0, sg, og, lw}, 8'h07);
    chk(en(), 8'h1d);
    $display("test startup done");

    wait_state(8'h03);
    wait_state(8'h02);
    wr(plp_pkg::ADDR_CONTROL, 8'h72);
    wait_state(8'h03);
    chk({7'h0, hc}, 8'h01);
    chk(en(), 8'h1d);
    wait_state(8'h02);
    rd(plp_pkg::ADDR_CONTROL, d);
    chk(d, 8'h70);
    wr(plp_pkg::ADDR_CONTROL, 8'h30);
    idle(2);
    chk({5'h0, high_lvl}, 8'h03);
    drv.storage_path_enable = 1'b0;
    idle(8);
    chk({6'h0, iso, bst}, 8'h00);
    drv.storage_path_enable = 1'b1;
    wait_state(8'h02);
    $display("test health and controls done");

    rd(plp_pkg::ADDR_FAULT, d);
    idle(1);
    chk({7'h0, irq_oe_n}, 8'h01);
    drv.sense_above_low = 1'b0;
    wait_state(8'h04);
    chk(en(), 8'h0b);
    chk({7'h0, lw}, 8'h00);
    chk({7'h0, irq_oe_n}, 8'h00);
    rd(plp_pkg::ADDR_FAULT, d);
    chk(d & 8'h01, 8'h01);
    idle(1);
    chk({7'h0, irq_oe_n}, 8'h00);
    wait_state(8'h00);
    drv.sense_above_low = 1'b1;
    wait_state(8'h02);
    $display("test input fault done");

    wr(plp_pkg::ADDR_MASK, 8'hff);
    rd(plp_pkg::ADDR_FAULT, d);
    rd(plp_pkg::ADDR_FAULT, d);
    idle(2);
    chk({7'h0, irq_oe_n}, 8'h01);
    drv.enable = 1'b0;
    wait_state(8'h04);
    chk({7'h0, irq_oe_n}, 8'h01);
    wait_state(8'h00);
    idle(20);
    rd(plp_pkg::ADDR_STATE, d);
    chk(d, 8'h00);
    drv.enable = 1'b1;
    wait_state(8'h02);
    $display("test enable and mask done");

    wr(plp_pkg::ADDR_MASK, 8'h00);
    drv.ref_valid = 1'b0;
    wait_state(8'h05);
    chk({7'h0, irq_oe_n}, 8'h00);
    drv.ref_valid = 1'b1;
    wait_state(8'h02);
    wr(plp_pkg::ADDR_CONTROL, 8'h31);
    idle(3);
    chk({7'h0, og}, 8'h00);
    wait_state(8'h02);
    wr(plp_pkg::ADDR_CONTROL, 8'h00);
    drv.sense_above_high = 1'b1;
    idle(12);
    rd(plp_pkg::ADDR_FAULT, d);
    chk(d & 8'h02, 8'h00);
    chk({7'h0, sw}, 8'h01);
    drv.sense_above_high = 1'b0;
    drv.temp_over_155 = 1'b1;
    wait_state(8'h06);
    chk(en(), 8'h00);
    drv.temp_over_155 = 1'b0;
    wait_state(8'h02);
    $display("test readiness and shutdown done");
    end_of_test();
  end
endmodule : power_loss_protection_fsm_test
